// >>> dv/prsd_board.sv
// Board strap resistors and platform clock source
`timescale 1ns/1ps
module prsd_board (
  input wire logic [3:0] plat_code,
  input wire logic [2:0] core_code,
  output logic [3:0] plat_pin,
  output logic [2:0] core_pin,
  output logic plat_clk
);
  // Every line driven, the device has no default ratio
  assign plat_pin = plat_code;
  assign core_pin = core_code;
  // Rate chosen to equal memory data rate, ranges kept by board choice
  initial plat_clk = 1'h0;
  always #300 plat_clk = ~plat_clk;
endmodule

// >>> dv/prsd_top_properties.sv
// Checker of capture, decode and memory enable at the top ports
`timescale 1ns/1ps
module prsd_top_properties
  import prsd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [RATIO_W-1:0] plat_ratio_mult,
  input wire logic plat_ratio_reserved,
  input wire logic [RATIO_W-1:0] core_ratio_num,
  input wire logic [RATIO_W-1:0] core_ratio_den,
  input wire logic core_ratio_reserved,
  input wire logic ratios_valid,
  input wire logic mem_clk_enable
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_valid_after_release: assert property ($fell(reset) |-> ##2 ratios_valid)
    else $error("ratios not valid after release");
  a_valid_holds: assert property (ratios_valid |=> ratios_valid)
    else $error("valid dropped");
  a_ratios_frozen: assert property (ratios_valid |=>
    $stable({plat_ratio_mult, plat_ratio_reserved, core_ratio_num, core_ratio_den,
    core_ratio_reserved}))
    else $error("ratios changed after capture");
  a_reset_clears: assert property ($past(reset) |-> !ratios_valid &&
    !mem_clk_enable && plat_ratio_mult == 5'h00 && core_ratio_num == 5'h00)
    else $error("outputs not cleared by reset");
  a_plat_reserved_zero: assert property (plat_ratio_reserved |->
    plat_ratio_mult == 5'h00)
    else $error("reserved platform code with ratio");
  a_plat_legal: assert property (ratios_valid && !plat_ratio_reserved |->
    plat_ratio_mult inside {5'h10, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09,
    5'h0A, 5'h0C, 5'h14})
    else $error("platform ratio out of table");
  a_core_reserved_zero: assert property (core_ratio_reserved |->
    core_ratio_num == 5'h00 && core_ratio_den == 5'h00)
    else $error("reserved core code with ratio");
  a_core_den_legal: assert property (ratios_valid && !core_ratio_reserved |->
    core_ratio_den inside {5'h01, 5'h02})
    else $error("core denominator out of table");
  a_core_num_legal: assert property (ratios_valid && !core_ratio_reserved |->
    core_ratio_num inside {5'h04, 5'h09, 5'h03, 5'h02, 5'h05, 5'h07})
    else $error("core numerator out of table");
  a_mem_single: assert property (mem_clk_enable |=> !mem_clk_enable ##1 !mem_clk_enable)
    else $error("memory enable too dense");
  a_mem_needs_valid: assert property (mem_clk_enable |-> ratios_valid)
    else $error("memory enable before capture");
endmodule
bind prsd_top prsd_top_properties u_props (.clk(clk), .reset(reset),
  .plat_ratio_mult(plat_ratio_mult), .plat_ratio_reserved(plat_ratio_reserved),
  .core_ratio_num(core_ratio_num), .core_ratio_den(core_ratio_den),
  .core_ratio_reserved(core_ratio_reserved), .ratios_valid(ratios_valid),
  .mem_clk_enable(mem_clk_enable));

// >>> dv/tb.sv
// Self-checking bench for the ratio strap decoder
`timescale 1ns/1ps
module tb;
  import prsd_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [3:0] plat_code = 4'h0;
  logic [2:0] core_code = 3'h0;
  logic [3:0] plat_pin;
  logic [2:0] core_pin;
  logic plat_clk, plat_res, core_res, valid, mem_en;
  logic [4:0] mult, num, den;
  int errors = 0;
  int checked = 0;
  logic [4:0] mult_tab [16] = '{5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
    5'h08, 5'h09, 5'h0A, 5'h00, 5'h0C, 5'h14, 5'h00, 5'h00};
  logic [4:0] num_tab [8] = '{5'h04, 5'h09, 5'h00, 5'h03, 5'h02, 5'h05, 5'h03, 5'h07};
  logic [4:0] den_tab [8] = '{5'h01, 5'h02, 5'h00, 5'h02, 5'h01, 5'h02, 5'h01, 5'h02};
  always #50 clk = ~clk;
  prsd_board board (.plat_code(plat_code), .core_code(core_code), .plat_pin(plat_pin),
    .core_pin(core_pin), .plat_clk(plat_clk));
  prsd_top dut (.clk(clk), .reset(reset), .platform_ratio_strap(plat_pin),
    .bus_control_strap(core_pin[2]), .address_latch_strap(core_pin[1]),
    .general_purpose_line2_strap(core_pin[0]), .platform_bus_clock(plat_clk),
    .plat_ratio_mult(mult), .plat_ratio_reserved(plat_res), .core_ratio_num(num),
    .core_ratio_den(den), .core_ratio_reserved(core_res), .ratios_valid(valid),
    .mem_clk_enable(mem_en));
  // ****************
  // Tasks
  // ****************
  task check(input logic [14:0] seen, input logic [14:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  task finish_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Straps settle during reset, well over two edges before release
  task restart(input logic [3:0] p, input logic [2:0] c);
    @(posedge clk);
    reset <= 1'h1;
    plat_code <= p;
    core_code <= c;
    repeat (3) @(posedge clk);
    #1;
    check({1'h0, valid, plat_res, core_res, mem_en, mult, num}, 15'h0000, "reset");
    @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    #1;
    check({14'h0000, valid}, 15'h0000, "valid too early");
    repeat (2) @(posedge clk);
    #1;
  endtask
  task test_decode;
    logic [4:0] m, n, d;
    for (int i = 0; i < 16; i++) begin
      restart(i[3:0], i[2:0]);
      m = mult_tab[i];
      n = num_tab[i % 8];
      d = den_tab[i % 8];
      check({8'h00, valid, plat_res, mult}, {8'h00, 1'h1, m == 5'h00, m}, "plat");
      check({4'h0, core_res, num, den}, {4'h0, n == 5'h00, n, d}, "core");
    end
  endtask
  task test_hold;
    restart(4'hD, 3'h7);
    @(posedge clk);
    plat_code <= 4'h1;
    core_code <= 3'h2;
    repeat (10) @(posedge clk);
    #1;
    check({mult, num, den}, {5'h14, 5'h07, 5'h02}, "ratios moved");
    check({12'h000, valid, plat_res, core_res}, 15'h0004, "flags moved");
  endtask
  // Any 72-cycle window holds six pulses of a 12-cycle period
  task test_mem;
    int n;
    restart(4'h2, 3'h4);
    n = 0;
    repeat (72) begin
      @(posedge clk);
      #1;
      if (mem_en === 1'h1) n++;
    end
    check(n[14:0], 15'h0006, "memory enable rate");
  endtask
  initial begin
    test_decode;
    test_hold;
    test_mem;
    finish_test;
  end
  initial begin
    #1000000;
    errors++;
    finish_test;
  end
endmodule

// >>> rtl/prsd_pkg.sv
// Package of constants and types for the ratio strap decoder
package prsd_pkg;
  localparam int PLAT_STRAP_W = 4;
  localparam int CORE_STRAP_W = 3;
  // Core ratio held as numerator and denominator, platform ratio as a multiplier, 5 bits each
  localparam int RATIO_W = 5;
  // Memory clock divides platform clock by this
  localparam int MEM_DIV = 2;
  localparam logic [0:0] MEM_DIV_LAST = 1'h1;
  localparam int SYNC_STAGES = 2;

  localparam logic [3:0] PLAT_16 = 4'h0;
  localparam logic [3:0] PLAT_2 = 4'h2;
  localparam logic [3:0] PLAT_3 = 4'h3;
  localparam logic [3:0] PLAT_4 = 4'h4;
  localparam logic [3:0] PLAT_5 = 4'h5;
  localparam logic [3:0] PLAT_6 = 4'h6;
  localparam logic [3:0] PLAT_8 = 4'h8;
  localparam logic [3:0] PLAT_9 = 4'h9;
  localparam logic [3:0] PLAT_10 = 4'hA;
  localparam logic [3:0] PLAT_12 = 4'hC;
  localparam logic [3:0] PLAT_20 = 4'hD;

  localparam logic [2:0] CORE_4_1 = 3'h0;
  localparam logic [2:0] CORE_9_2 = 3'h1;
  localparam logic [2:0] CORE_3_2 = 3'h3;
  localparam logic [2:0] CORE_2_1 = 3'h4;
  localparam logic [2:0] CORE_5_2 = 3'h5;
  localparam logic [2:0] CORE_3_1 = 3'h6;
  localparam logic [2:0] CORE_7_2 = 3'h7;

  localparam logic [4:0] RATIO_ZERO = 5'h00;
  localparam logic [4:0] DEN_ONE = 5'h01;
  localparam logic [4:0] DEN_TWO = 5'h02;

  typedef enum logic [1:0] {
    PRSD_IN_RESET,
    PRSD_CAPTURE,
    PRSD_LOCKED
  } prsd_state_type;
endpackage

// >>> rtl/prsd_strap_if.sv
// Interface carrying synchronised strap levels between modules
`timescale 1ns/1ps
interface prsd_strap_if;
  import prsd_pkg::*;
  logic [PLAT_STRAP_W-1:0] plat;
  logic [CORE_STRAP_W-1:0] core;
  modport source (output plat, output core);
  modport sink (input plat, input core);
endinterface

// >>> rtl/prsd_sync.sv
// Two-stage synchroniser for the strap pins
`timescale 1ns/1ps
module prsd_sync
  import prsd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [PLAT_STRAP_W-1:0] plat_pin,
  input wire logic [CORE_STRAP_W-1:0] core_pin,
  prsd_strap_if.source strap
);
  // ****************************************
  // First stage is read only by the second
  // ****************************************
  logic [PLAT_STRAP_W-1:0] plat_meta;
  logic [CORE_STRAP_W-1:0] core_meta;
  logic [PLAT_STRAP_W-1:0] plat_sync;
  logic [CORE_STRAP_W-1:0] core_sync;

  always_ff @(posedge clk) begin
    plat_meta <= plat_pin;
    core_meta <= core_pin;
    plat_sync <= plat_meta;
    core_sync <= core_meta;
  end

  assign strap.plat = plat_sync;
  assign strap.core = core_sync;
endmodule

// >>> rtl/prsd_top.sv
// Power-up strap capture and ratio decode with memory clock enable
//
// Contract
// - Sample platform strap at reset, set ratio
// - Decode platform code; flag reserved codes
// - Memory clock is half platform clock
// - Sample three control straps for core ratio
// - Decode core code; flag reserved 010
`timescale 1ns/1ps
module prsd_top
  import prsd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [PLAT_STRAP_W-1:0] platform_ratio_strap,
  input wire logic bus_control_strap,
  input wire logic address_latch_strap,
  input wire logic general_purpose_line2_strap,
  input wire logic platform_bus_clock,
  output logic [RATIO_W-1:0] plat_ratio_mult,
  output logic plat_ratio_reserved,
  output logic [RATIO_W-1:0] core_ratio_num,
  output logic [RATIO_W-1:0] core_ratio_den,
  output logic core_ratio_reserved,
  output logic ratios_valid,
  output logic mem_clk_enable
);
  // ****************************************
  // Strap synchronisation
  // ****************************************
  prsd_strap_if strap();
  logic [CORE_STRAP_W-1:0] core_pins;

  // Bit order: bus control is the most significant
  assign core_pins = {bus_control_strap, address_latch_strap, general_purpose_line2_strap};

  prsd_sync u_sync (
    .clk(clk),
    .reset(reset),
    .plat_pin(platform_ratio_strap),
    .core_pin(core_pins),
    .strap(strap)
  );

  // ****************************************
  // Decode
  // ****************************************
  logic [PLAT_STRAP_W-1:0] plat_level;
  logic [CORE_STRAP_W-1:0] core_level;
  logic plat_is_16;
  logic plat_is_2;
  logic plat_is_3;
  logic plat_is_4;
  logic plat_is_5;
  logic plat_is_6;
  logic plat_is_8;
  logic plat_is_9;
  logic plat_is_10;
  logic plat_is_12;
  logic plat_is_20;
  logic core_is_4_1;
  logic core_is_9_2;
  logic core_is_3_2;
  logic core_is_2_1;
  logic core_is_5_2;
  logic core_is_3_1;
  logic core_is_7_2;
  logic core_whole;
  logic [RATIO_W-1:0] dec_plat;
  logic dec_plat_rsv;
  logic [RATIO_W-1:0] dec_num;
  logic [RATIO_W-1:0] dec_den;
  logic dec_core_rsv;

  assign plat_level = strap.plat;
  assign core_level = strap.core;

  // One match wire per table row
  assign plat_is_16 = (plat_level == PLAT_16);
  assign plat_is_2 = (plat_level == PLAT_2);
  assign plat_is_3 = (plat_level == PLAT_3);
  assign plat_is_4 = (plat_level == PLAT_4);
  assign plat_is_5 = (plat_level == PLAT_5);
  assign plat_is_6 = (plat_level == PLAT_6);
  assign plat_is_8 = (plat_level == PLAT_8);
  assign plat_is_9 = (plat_level == PLAT_9);
  assign plat_is_10 = (plat_level == PLAT_10);
  assign plat_is_12 = (plat_level == PLAT_12);
  assign plat_is_20 = (plat_level == PLAT_20);

  // Reserved codes give zero so nothing downstream trusts them
  assign dec_plat = plat_is_16 ? 5'h10 :
                    plat_is_2 ? 5'h02 :
                    plat_is_3 ? 5'h03 :
                    plat_is_4 ? 5'h04 :
                    plat_is_5 ? 5'h05 :
                    plat_is_6 ? 5'h06 :
                    plat_is_8 ? 5'h08 :
                    plat_is_9 ? 5'h09 :
                    plat_is_10 ? 5'h0A :
                    plat_is_12 ? 5'h0C :
                    plat_is_20 ? 5'h14 : RATIO_ZERO;
  // Flag from the match wires, so a wrong ratio entry cannot hide it
  assign dec_plat_rsv = ~(plat_is_16 | plat_is_2 | plat_is_3 |
                          plat_is_4 | plat_is_5 | plat_is_6 |
                          plat_is_8 | plat_is_9 | plat_is_10 |
                          plat_is_12 | plat_is_20);

  // ****************************************
  // Core strap decode
  // ****************************************
  assign core_is_4_1 = (core_level == CORE_4_1);
  assign core_is_9_2 = (core_level == CORE_9_2);
  assign core_is_3_2 = (core_level == CORE_3_2);
  assign core_is_2_1 = (core_level == CORE_2_1);
  assign core_is_5_2 = (core_level == CORE_5_2);
  assign core_is_3_1 = (core_level == CORE_3_1);
  assign core_is_7_2 = (core_level == CORE_7_2);
  // Whole-number ratios have denominator one
  assign core_whole = core_is_4_1 | core_is_2_1 | core_is_3_1;

  assign dec_num = core_is_4_1 ? 5'h04 :
                   core_is_9_2 ? 5'h09 :
                   core_is_3_2 ? 5'h03 :
                   core_is_2_1 ? 5'h02 :
                   core_is_5_2 ? 5'h05 :
                   core_is_3_1 ? 5'h03 :
                   core_is_7_2 ? 5'h07 : RATIO_ZERO;
  assign dec_core_rsv = ~(core_is_4_1 | core_is_9_2 | core_is_3_2 | core_is_2_1 |
                          core_is_5_2 | core_is_3_1 | core_is_7_2);
  assign dec_den = dec_core_rsv ? RATIO_ZERO :
                   core_whole ? DEN_ONE : DEN_TWO;

  // ****************************************
  // Capture sequence
  // ****************************************
  prsd_state_type state;
  prsd_state_type next_state;
  logic capture;

  // One settling cycle lets the synchroniser deliver the levels sampled at the last edge in reset
  always_comb begin
    next_state = state;
    case (state)
      PRSD_IN_RESET: next_state = PRSD_CAPTURE;
      PRSD_CAPTURE: next_state = PRSD_LOCKED;
      PRSD_LOCKED: next_state = PRSD_LOCKED;
      default: next_state = PRSD_IN_RESET;
    endcase
  end

  assign capture = (state == PRSD_CAPTURE);

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= PRSD_IN_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Later pin activity is ignored once locked
  always_ff @(posedge clk) begin
    if (reset) begin
      plat_ratio_mult <= RATIO_ZERO;
      plat_ratio_reserved <= 1'h0;
      core_ratio_num <= RATIO_ZERO;
      core_ratio_den <= RATIO_ZERO;
      core_ratio_reserved <= 1'h0;
      ratios_valid <= 1'h0;
    end else if (capture) begin
      plat_ratio_mult <= dec_plat;
      plat_ratio_reserved <= dec_plat_rsv;
      core_ratio_num <= dec_num;
      core_ratio_den <= dec_den;
      core_ratio_reserved <= dec_core_rsv;
      ratios_valid <= 1'h1;
    end
  end

  // ****************************************
  // Memory clock enable
  // ****************************************
  // Platform clock is a pin here, so it is synchronised and edge counted
  logic pbc_meta;
  logic pbc_sync;
  logic pbc_prev;
  logic pbc_rise;
  logic mem_phase;
  logic mem_fire;

  // Prev tracks the synced level through reset, so release shows no false edge
  always_ff @(posedge clk) begin
    pbc_meta <= platform_bus_clock;
    pbc_sync <= pbc_meta;
    pbc_prev <= pbc_sync;
  end

  assign pbc_rise = pbc_sync & ~pbc_prev;
  assign mem_fire = pbc_rise && (mem_phase == MEM_DIV_LAST) && ratios_valid;

  // Limitation: only valid while platform clock is below half of clk
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_phase <= 1'h0;
    end else if (pbc_rise) begin
      mem_phase <= mem_phase + 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_clk_enable <= 1'h0;
    end else begin
      mem_clk_enable <= mem_fire;
    end
  end
endmodule
